/* rtl/lic_pkg.sv */
// Constants shared by the indicator-lamp controller and its blink engine.
package lic_pkg;

  // ****************************************
  // Register map and field layout
  // ****************************************
  localparam int         NUM_LAMPS      = 2;
  localparam logic [29:0] IDX_CTRL0     = 30'h0000_8c80;
  localparam logic [29:0] IDX_CTRL1     = 30'h0000_8c81;
  localparam logic [29:0] IDX_POLARITY  = 30'h0000_8c83;
  localparam logic [29:0] IDX_PERIOD    = 30'h0000_8c84;
  localparam logic [29:0] IDX_STATUS    = 30'h0000_8c85;
  localparam int         CTRL_SRC_LSB   = 0;
  localparam int         CTRL_STYLE_BIT = 5;
  localparam int         CTRL_GATE_BIT  = 6;
  localparam int         CTRL_EN_BIT    = 7;
  localparam logic [15:0] CTRL_MASK     = 16'h00ff;
  localparam logic [15:0] CTRL_RESET    = 16'h0080;
  localparam int         POL_W          = 2;
  localparam logic [15:0] POL_MASK      = 16'h000f;
  localparam logic [15:0] POL_RESET     = 16'h0000;
  localparam logic [15:0] PERIOD_RESET  = 16'h0032;
  localparam int         STAT_GRADE_LSB = 4;

  // ****************************************
  // Polarity codes
  // ****************************************
  localparam logic [1:0] POL_AUTO = 2'h0;
  localparam logic [1:0] POL_HIGH = 2'h1;
  localparam logic [1:0] POL_LOW  = 2'h2;

  // ****************************************
  // Source codes
  // ****************************************
  localparam logic [4:0] SRC_LINK_BOTH   = 5'h00;
  localparam logic [4:0] SRC_LINK_TX     = 5'h01;
  localparam logic [4:0] SRC_LINK_RX     = 5'h02;
  localparam logic [4:0] SRC_LINK_ONLY   = 5'h03;
  localparam logic [4:0] SRC_BOTH        = 5'h04;
  localparam logic [4:0] SRC_TX          = 5'h05;
  localparam logic [4:0] SRC_RX          = 5'h06;
  localparam logic [4:0] SRC_LINK_ERR    = 5'h08;
  localparam logic [4:0] SRC_RX_ERR      = 5'h09;
  localparam logic [4:0] SRC_ANY_ERR     = 5'h0a;
  localparam logic [4:0] SRC_TRANSMIT_PACKET_START      = 5'h0b;
  localparam logic [4:0] SRC_RECEIVE_PACKET_START      = 5'h0c;
  localparam logic [4:0] SRC_ON          = 5'h0d;
  localparam logic [4:0] SRC_OFF         = 5'h0e;
  localparam logic [4:0] SRC_BLINK       = 5'h0f;
  localparam logic [4:0] SRC_HIGH_SWING  = 5'h10;
  localparam logic [4:0] SRC_LOW_SWING   = 5'h11;
  localparam logic [4:0] SRC_LEADER      = 5'h12;
  localparam logic [4:0] SRC_FOLLOWER    = 5'h13;
  localparam logic [4:0] SRC_MISMATCH    = 5'h14;
  localparam logic [4:0] SRC_NEG_GOOD    = 5'h15;
  localparam logic [4:0] SRC_NEG_DONE    = 5'h16;
  localparam logic [4:0] SRC_TIMESTAMP   = 5'h17;
  localparam logic [4:0] SRC_LOCAL_RX_OK = 5'h18;
  localparam logic [4:0] SRC_REMOTE_OK   = 5'h19;
  localparam logic [4:0] SRC_REF_CLK     = 5'h1a;
  localparam logic [4:0] SRC_TX_CLK      = 5'h1b;
  localparam logic [4:0] SRC_FAST_CLK    = 5'h1c;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int WINDOW_MS     = 1000;
  localparam int GRADE_STEPS   = 10;
  localparam int STEP_MS       = WINDOW_MS / GRADE_STEPS;
  localparam logic [3:0] GRADE_MAX = 4'ha;

endpackage

/* rtl/lic_blink.sv */
// Blink engine for one lamp: fixed-rate or activity-graded on/off timing.
`timescale 1ns/1ps
module lic_blink (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Millisecond enable
  input  wire logic        tick,
  // Configuration
  input  wire logic        style,
  input  wire logic [15:0] period,
  // Activity and result
  input  wire logic        act,
  output logic             lamp_on,
  output logic [3:0]       grade
);

  typedef enum logic [1:0] {
    LIC_IDLE = 2'b00,
    LIC_ON   = 2'b01,
    LIC_OFF  = 2'b10
  } lic_phase_t;

  typedef struct packed {
    lic_phase_t  phase;
    logic [19:0] cnt;
    logic        seen;
    logic        tick_act;
    logic [10:0] win;
    logic [6:0]  step;
    logic [3:0]  meas;
    logic [3:0]  grade;
  } lic_blink_t;

  lic_blink_t  r;
  lic_blink_t  n;
  logic [19:0] unit;
  logic [19:0] on_len;
  logic [19:0] off_len;

  always_comb begin
    unit = (period == 16'h0000) ? 20'h00001 : {4'h0, period};
    if (style) begin
      // Busier port: shorter on, longer off.
      on_len  = 20'(unit * {16'h0000, lic_pkg::GRADE_MAX + 4'h1 - r.grade});
      off_len = 20'(unit * {16'h0000, r.grade + 4'h1});
    end else begin
      on_len  = unit;
      off_len = unit;
    end
  end

  always_comb begin
    n = r;
    n.seen     = act | r.seen;
    n.tick_act = act | (r.tick_act & ~tick);
    if (tick) begin
      if (r.tick_act) begin
        if (r.step == 7'(lic_pkg::STEP_MS - 1)) begin
          n.step = 7'h00;
          if (r.meas != lic_pkg::GRADE_MAX) begin
            n.meas = r.meas + 4'h1;
          end
        end else begin
          n.step = r.step + 7'h01;
        end
      end
      if (r.win == 11'(lic_pkg::WINDOW_MS - 1)) begin
        n.grade = n.meas;
        n.meas  = 4'h0;
        n.step  = 7'h00;
        n.win   = 11'h000;
      end else begin
        n.win = r.win + 11'h001;
      end
    end
    unique case (r.phase)
      LIC_IDLE: begin
        if (act) begin
          n.phase = LIC_ON;
          n.cnt   = 20'h00000;
          n.seen  = 1'b0;
        end
      end
      LIC_ON: begin
        if (tick) begin
          if (r.cnt + 20'h00001 >= on_len) begin
            n.phase = LIC_OFF;
            n.cnt   = 20'h00000;
          end else begin
            n.cnt = r.cnt + 20'h00001;
          end
        end
      end
      LIC_OFF: begin
        if (tick) begin
          if (r.cnt + 20'h00001 >= off_len) begin
            n.phase = (r.seen | act) ? LIC_ON : LIC_IDLE;
            n.cnt   = 20'h00000;
            n.seen  = 1'b0;
          end else begin
            n.cnt = r.cnt + 20'h00001;
          end
        end
      end
      default: begin
        n.phase = LIC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign lamp_on = (r.phase == LIC_ON);
  assign grade   = r.grade;

endmodule

/* rtl/lic_top.sv */
// Indicator-lamp controller for one PHY port with a classic Wishbone register slave.
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
module lic_top #(
  parameter int unsigned TICK_CYCLES = lic_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Link and traffic indications
  input  wire logic        link_up,
  input  wire logic        tx_activity,
  input  wire logic        rx_activity,
  input  wire logic        tx_error,
  input  wire logic        rx_error,
  input  wire logic        transmit_packet_start,
  input  wire logic        receive_packet_start,
  // Status indications
  input  wire logic        high_swing_level,
  input  wire logic        low_swing_level,
  input  wire logic        leader_role,
  input  wire logic        follower_role,
  input  wire logic        link_config_mismatch,
  input  wire logic        negotiation_link_good,
  input  wire logic        negotiation_done,
  input  wire logic        timestamp_timer_out,
  input  wire logic        local_receiver_ok,
  input  wire logic        remote_receiver_ok,
  // Clock sources for the clock-out codes
  input  wire logic        ref_clock_out,
  input  wire logic        transmit_clock_out,
  input  wire logic        fast_clock_out,
  // Sensed lamp wiring, one bit per lamp
  input  wire logic [1:0]  autosense_active_low,
  // Lamp pins
  output logic [1:0]       lamp_out
);

  localparam int NL = lic_pkg::NUM_LAMPS;

  typedef struct packed {
    logic [NL-1:0][15:0] ctrl;
    logic [15:0]         pol;
    logic [15:0]         period;
    logic [NL-1:0]       lamp;
    logic                ack;
    logic [31:0]         rdata;
    logic [15:0]         div;
    logic                tick;
  } lic_top_state_t;

  lic_top_state_t r;
  lic_top_state_t n;

  logic [NL-1:0]      blink_act;
  logic [NL-1:0]      blink_on;
  logic [NL-1:0][3:0] grade;
  logic [NL-1:0]      lamp_pin;
  logic [NL-1:0]      lamp_logic;
  logic [29:0]        word_idx;
  logic               access;

  assign word_idx = wb_adr_i[31:2];
  // A request is taken only while ack is low, so a master that keeps stb up through the
  // answer cycle is not answered twice.
  assign access   = wb_cyc_i & wb_stb_i & ~r.ack;

  // ****************************************
  // Blink engines
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NL; g++) begin : gen_lamp
      lic_blink u_blink (
        .clk     (clk),
        .srst    (srst),
        .tick    (r.tick),
        .style   (r.ctrl[g][lic_pkg::CTRL_STYLE_BIT]),
        .period  (r.period),
        .act     (blink_act[g]),
        .lamp_on (blink_on[g]),
        .grade   (grade[g])
      );
    end
  endgenerate

  // ****************************************
  // Source selection, gating and polarity
  // ****************************************
  always_comb begin
    logic [4:0] src;
    logic       use_blink;
    logic       stat;
    logic       need_link;
    logic       bypass;
    logic       on;
    logic       low;
    logic [1:0] pol;
    src        = 5'h00;
    use_blink  = 1'b0;
    stat       = 1'b0;
    need_link  = 1'b0;
    bypass     = 1'b0;
    on         = 1'b0;
    low        = 1'b0;
    pol        = 2'h0;
    blink_act  = '0;
    lamp_pin   = '0;
    lamp_logic = '0;
    for (int i = 0; i < NL; i++) begin
      src       = r.ctrl[i][lic_pkg::CTRL_SRC_LSB +: 5];
      use_blink = 1'b0;
      stat      = 1'b0;
      need_link = 1'b0;
      bypass    = 1'b0;
      unique case (src)
        lic_pkg::SRC_LINK_BOTH: begin
          use_blink    = 1'b1;
          blink_act[i] = tx_activity | rx_activity;
          need_link    = 1'b1;
        end
        lic_pkg::SRC_LINK_TX: begin
          use_blink    = 1'b1;
          blink_act[i] = tx_activity;
          need_link    = 1'b1;
        end
        lic_pkg::SRC_LINK_RX: begin
          use_blink    = 1'b1;
          blink_act[i] = rx_activity;
          need_link    = 1'b1;
        end
        lic_pkg::SRC_LINK_ONLY: begin
          stat      = 1'b1;
          need_link = 1'b1;
        end
        lic_pkg::SRC_BOTH: begin
          use_blink    = 1'b1;
          blink_act[i] = tx_activity | rx_activity;
        end
        lic_pkg::SRC_TX: begin
          use_blink    = 1'b1;
          blink_act[i] = tx_activity;
        end
        lic_pkg::SRC_RX: begin
          use_blink    = 1'b1;
          blink_act[i] = rx_activity;
        end
        lic_pkg::SRC_LINK_ERR: begin
          use_blink    = 1'b1;
          blink_act[i] = tx_error | rx_error;
          need_link    = 1'b1;
        end
        lic_pkg::SRC_RX_ERR: begin
          use_blink    = 1'b1;
          blink_act[i] = rx_error;
        end
        lic_pkg::SRC_ANY_ERR: begin
          use_blink    = 1'b1;
          blink_act[i] = tx_error | rx_error;
        end
        lic_pkg::SRC_TRANSMIT_PACKET_START: begin
          use_blink    = 1'b1;
          blink_act[i] = transmit_packet_start;
        end
        lic_pkg::SRC_RECEIVE_PACKET_START: begin
          use_blink    = 1'b1;
          blink_act[i] = receive_packet_start;
        end
        lic_pkg::SRC_ON: begin
          stat = 1'b1;
        end
        lic_pkg::SRC_OFF: begin
          stat = 1'b0;
        end
        lic_pkg::SRC_BLINK: begin
          use_blink    = 1'b1;
          blink_act[i] = 1'b1;
        end
        lic_pkg::SRC_HIGH_SWING: begin
          stat      = high_swing_level;
          need_link = r.ctrl[i][lic_pkg::CTRL_GATE_BIT];
        end
        lic_pkg::SRC_LOW_SWING: begin
          stat      = low_swing_level;
          need_link = r.ctrl[i][lic_pkg::CTRL_GATE_BIT];
        end
        lic_pkg::SRC_LEADER: begin
          stat      = leader_role;
          need_link = r.ctrl[i][lic_pkg::CTRL_GATE_BIT];
        end
        lic_pkg::SRC_FOLLOWER: begin
          stat      = follower_role;
          need_link = r.ctrl[i][lic_pkg::CTRL_GATE_BIT];
        end
        lic_pkg::SRC_MISMATCH: begin
          stat = link_config_mismatch;
        end
        lic_pkg::SRC_NEG_GOOD: begin
          stat = negotiation_link_good;
        end
        lic_pkg::SRC_NEG_DONE: begin
          stat = negotiation_done;
        end
        lic_pkg::SRC_TIMESTAMP: begin
          stat = timestamp_timer_out;
        end
        lic_pkg::SRC_LOCAL_RX_OK: begin
          stat = local_receiver_ok;
        end
        lic_pkg::SRC_REMOTE_OK: begin
          stat = remote_receiver_ok;
        end
        lic_pkg::SRC_REF_CLK: begin
          stat   = ref_clock_out;
          bypass = 1'b1;
        end
        lic_pkg::SRC_TX_CLK: begin
          stat   = transmit_clock_out;
          bypass = 1'b1;
        end
        lic_pkg::SRC_FAST_CLK: begin
          stat   = fast_clock_out;
          bypass = 1'b1;
        end
        default: begin
          stat = 1'b0;
        end
      endcase
      on = use_blink ? blink_on[i] : stat;
      if (need_link && !link_up) begin
        on = 1'b0;
      end
      if (!r.ctrl[i][lic_pkg::CTRL_EN_BIT]) begin
        on = 1'b0;
      end
      pol = r.pol[i*lic_pkg::POL_W +: lic_pkg::POL_W];
      unique case (pol)
        lic_pkg::POL_AUTO: low = autosense_active_low[i];
        lic_pkg::POL_HIGH: low = 1'b0;
        lic_pkg::POL_LOW:  low = 1'b1;
        default:           low = 1'b0;
      endcase
      lamp_logic[i] = on;
      // Clock-out waveforms leave without inversion so the pin shows the source as is.
      lamp_pin[i] = bypass ? on : (on ^ low);
    end
  end

  // ****************************************
  // Registers, bus slave and tick divider
  // ****************************************
  always_comb begin
    n        = r;
    n.ack    = access;
    n.lamp   = lamp_pin;
    n.tick   = 1'b0;
    // The divider free-runs from reset, so the first tick after a new setup may come early.
    // The blink engines count whole ticks only, so this costs at most one tick of lamp time.
    n.div    = r.div + 16'h0001;
    if (r.div == 16'(TICK_CYCLES - 1)) begin
      n.div  = 16'h0000;
      n.tick = 1'b1;
    end
    n.rdata = 32'h0000_0000;
    if (access && !wb_we_i) begin
      unique case (word_idx)
        lic_pkg::IDX_CTRL0:    n.rdata = {16'h0000, r.ctrl[0]};
        lic_pkg::IDX_CTRL1:    n.rdata = {16'h0000, r.ctrl[1]};
        lic_pkg::IDX_POLARITY: n.rdata = {16'h0000, r.pol};
        lic_pkg::IDX_PERIOD:   n.rdata = {16'h0000, r.period};
        lic_pkg::IDX_STATUS: begin
          n.rdata[NL-1:0] = lamp_logic;
          n.rdata[lic_pkg::STAT_GRADE_LSB +: 8] = {grade[1], grade[0]};
        end
        default:               n.rdata = 32'h0000_0000;
      endcase
    end
    // Writes land on the taking edge, the same edge that raises ack, so a read that follows a write
    // always returns the new value.
    if (access && wb_we_i) begin
      for (int b = 0; b < 2; b++) begin
        if (wb_sel_i[b]) begin
          unique case (word_idx)
            lic_pkg::IDX_CTRL0: begin
              n.ctrl[0][b*8 +: 8] = wb_dat_i[b*8 +: 8] & lic_pkg::CTRL_MASK[b*8 +: 8];
            end
            lic_pkg::IDX_CTRL1: begin
              n.ctrl[1][b*8 +: 8] = wb_dat_i[b*8 +: 8] & lic_pkg::CTRL_MASK[b*8 +: 8];
            end
            lic_pkg::IDX_POLARITY: begin
              n.pol[b*8 +: 8] = wb_dat_i[b*8 +: 8] & lic_pkg::POL_MASK[b*8 +: 8];
            end
            lic_pkg::IDX_PERIOD: begin
              n.period[b*8 +: 8] = wb_dat_i[b*8 +: 8];
            end
            default: begin
              n.period = r.period;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r        <= '0;
      r.ctrl   <= {NL{lic_pkg::CTRL_RESET}};
      r.pol    <= lic_pkg::POL_RESET;
      r.period <= lic_pkg::PERIOD_RESET;
    end else begin
      r <= n;
    end
  end

  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.rdata;
  assign lamp_out = r.lamp;

endmodule

/* sim/lic_lamp_model.sv */
// External lamps hanging on the two lamp pins, with their sensed wiring.
`timescale 1ns/1ps
module lic_lamp_model #(
  parameter logic [1:0] WIRED_LOW = 2'h1
) (
  // Lamp pins
  input  wire logic [1:0] lamp_out,
  // Sensed wiring and light
  output logic [1:0]      autosense_active_low,
  output logic [1:0]      lit
);
  // A lamp wired active low lights while its pin sinks current, so it sees the pin inverted.
  assign autosense_active_low = WIRED_LOW;
  assign lit                  = lamp_out ^ WIRED_LOW;
endmodule

/* sim/lic_top_checker.sv */
// Port-level assertions for the indicator-lamp controller.
`timescale 1ns/1ps
module lic_top_checker #(
  parameter int unsigned TICK_CYCLES = 4
) (
  // Clock, reset and bus
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Lamp side
  input wire logic        negotiation_link_good,
  input wire logic [1:0]  lamp_out
);
  // ****************************************
  // Shadow of the lamp 0 setup
  // ****************************************
  typedef struct packed {
    logic [7:0] ctl;
    logic [1:0] pol;
    logic [1:0] age;
  } lic_shadow_t;
  lic_shadow_t s_reg;
  lic_shadow_t s_next;
  logic        take;
  logic        stl;
  logic        en;
  logic [4:0]  src;
  assign take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign stl  = s_reg.age == 2'h3;
  assign en   = s_reg.ctl[7];
  assign src  = s_reg.ctl[4:0];
  // The age counter keeps the lamp checks quiet until a new setup has had time to reach the pin.
  always_comb begin
    s_next = s_reg;
    s_next.age = stl ? 2'h3 : s_reg.age + 2'h1;
    if (take && wb_adr_i[31:2] == lic_pkg::IDX_CTRL0) begin
      s_next.ctl = wb_dat_i[7:0];
      s_next.age = 2'h0;
    end
    if (take && wb_adr_i[31:2] == lic_pkg::IDX_POLARITY) begin
      s_next.pol = wb_dat_i[1:0];
      s_next.age = 2'h0;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg <= {8'h80, 4'h0};
    end else begin
      s_reg <= s_next;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_reset_quiet: assert property (disable iff (1'b0) srst |=> !wb_ack_o && lamp_out == 2'h0) else $error("busy after reset");
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("late ack");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i)) else $error("ack without request");
  a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data without ack");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0) else $error("upper data not zero");
  a_pol_reserved: assert property (wb_ack_o && $past(wb_adr_i[31:2]) == lic_pkg::IDX_POLARITY
    |-> wb_dat_o[15:4] == 12'h0) else $error("reserved polarity bits set");
  a_lamp_forced_off: assert property (stl && s_reg.pol == lic_pkg::POL_HIGH && (!en || src == lic_pkg::SRC_OFF)
    |-> !lamp_out[0]) else $error("lamp lit while off");
  a_lamp_on: assert property (stl && en && s_reg.pol == lic_pkg::POL_HIGH && src == lic_pkg::SRC_ON
    |-> lamp_out[0]) else $error("lamp dark while on");
  a_low_inverts: assert property (stl && en && s_reg.pol == lic_pkg::POL_LOW && src == lic_pkg::SRC_ON
    |-> !lamp_out[0]) else $error("active low not inverted");
  a_status_follow: assert property ((stl && en && s_reg.pol == lic_pkg::POL_HIGH && src == lic_pkg::SRC_NEG_GOOD
    && $stable(negotiation_link_good))[*3] |-> lamp_out[0] == negotiation_link_good) else $error("status lamp wrong");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_status: cover property (stl && en && src == lic_pkg::SRC_NEG_GOOD && lamp_out[0]);
  c_blink: cover property ($rose(lamp_out[0]) && src == lic_pkg::SRC_BOTH);
endmodule
bind lic_top lic_top_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .negotiation_link_good(negotiation_link_good), .lamp_out(lamp_out));

/* sim/testbench.sv */
// Self-checking bench for the indicator-lamp controller.
`timescale 1ns/1ps
module testbench;
  // ****************************************
  // Signals
  // ****************************************
  localparam int unsigned TICKS = 4;
  localparam logic [1:0] W = 2'h1;
  logic clk, ack, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic link = 1'b0, txa = 1'b0, run = 1'b0, smp = 1'b0, kcnt = 1'b0;
  logic [31:0] adr = 32'h0, wdat = 32'h0, rdat;
  logic [9:0] st = 10'h0;
  logic [4:0] misc = 5'h0;
  logic [2:0] ck = 3'h0;
  logic [1:0] pins, sense, lit;
  int errors = 0, checks_done = 0, seed = 94, cnt = 0;
  logic [31:0] expq[$];
  lic_top #(.TICK_CYCLES(TICKS)) dut_u (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .link_up(link),
    .tx_activity(txa), .rx_activity(misc[4]), .tx_error(misc[3]), .rx_error(misc[2]),
    .transmit_packet_start(misc[1]), .receive_packet_start(misc[0]), .high_swing_level(st[0]),
    .low_swing_level(st[1]), .leader_role(st[2]), .follower_role(st[3]), .link_config_mismatch(st[4]),
    .negotiation_link_good(st[5]), .negotiation_done(st[6]), .timestamp_timer_out(st[7]),
    .local_receiver_ok(st[8]), .remote_receiver_ok(st[9]), .ref_clock_out(ck[0]), .transmit_clock_out(ck[1]),
    .fast_clock_out(ck[2]), .autosense_active_low(sense), .lamp_out(pins));
  lic_lamp_model #(.WIRED_LOW(W)) lamp_u (.lamp_out(pins), .autosense_active_low(sense), .lit(lit));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [29:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'h0};
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) errors++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [29:0] idx, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, idx, 32'h0);
  endtask
  task automatic look(input logic [1:0] e);
    repeat (4) @(posedge clk);
    expq.push_back({30'h0, e});
    smp <= 1'b1;
    @(posedge clk);
    smp <= 1'b0;
  endtask
  // Counts lit cycles of lamp 0 over a window that spans whole blink periods.
  task automatic tally(input int e);
    run <= 1'b1;
    repeat (96) @(posedge clk);
    run <= 1'b0;
    kcnt <= 1'b1;
    smp <= 1'b1;
    expq.push_back(32'(e));
    @(posedge clk);
    smp <= 1'b0;
    kcnt <= 1'b0;
  endtask
  function automatic logic lamp_lit(input int i, input logic on, input logic [1:0] p);
    logic pin;
    pin = (p == lic_pkg::POL_LOW) ? !on : (p == lic_pkg::POL_AUTO) ? on ^ W[i] : on;
    return pin ^ W[i];
  endfunction
  always @(posedge clk) begin
    if (!run)
      cnt <= 0;
    else if (lit[0] === 1'b1)
      cnt <= cnt + 1;
    if ((ack === 1'b1 && we === 1'b0) || smp === 1'b1)
      check(kcnt ? 32'(cnt) : (smp ? {30'h0, lit} : rdat), expq.pop_front());
  end
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    final_report();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    logic [7:0] codes [3];
    logic [31:0] r;
    codes = '{8'h8d, 8'h8e, 8'h0d};
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(lic_pkg::IDX_CTRL0, 32'h80);
    rd(lic_pkg::IDX_POLARITY, 32'h0);
    rd(30'h8c82, 32'h0);
    bus(1'b1, lic_pkg::IDX_POLARITY, 32'hffff);
    rd(lic_pkg::IDX_POLARITY, 32'hf);
    r = $random(seed);
    bus(1'b1, lic_pkg::IDX_CTRL1, r);
    rd(lic_pkg::IDX_CTRL1, {24'h0, r[7:0]});
    $display("registers done");
    for (int p = 0; p < 3; p++) begin
      bus(1'b1, lic_pkg::IDX_POLARITY, {28'h0, p[1:0], p[1:0]});
      foreach (codes[k]) begin
        bus(1'b1, lic_pkg::IDX_CTRL0, {24'h0, codes[k]});
        bus(1'b1, lic_pkg::IDX_CTRL1, {24'h0, codes[k]});
        look({lamp_lit(1, codes[k] == 8'h8d, p[1:0]), lamp_lit(0, codes[k] == 8'h8d, p[1:0])});
      end
    end
    $display("static and polarity done");
    bus(1'b1, lic_pkg::IDX_POLARITY, 32'h1);
    bus(1'b1, lic_pkg::IDX_CTRL1, 32'h8e);
    for (int g = 0; g < 3; g++) begin
      link <= (g == 2);
      for (int c = 16; c < 26; c++) begin
        st <= 10'($random(seed));
        misc <= 5'($random(seed));
        bus(1'b1, lic_pkg::IDX_CTRL0, 32'h80 | ((g > 0) << 6) | c);
        look({lamp_lit(1, 1'b0, 2'h0), lamp_lit(0, st[c - 16] && !(g == 1 && c < 20), 2'h1)});
      end
    end
    $display("status codes done");
    bus(1'b1, lic_pkg::IDX_POLARITY, 32'h2);
    for (int c = 26; c < 29; c++) begin
      for (int v = 0; v < 2; v++) begin
        ck <= v ? 3'h1 << (c - 26) : ~(3'h1 << (c - 26));
        bus(1'b1, lic_pkg::IDX_CTRL0, 32'h80 | c);
        look({lamp_lit(1, 1'b0, 2'h0), 1'(v) ^ W[0]});
      end
    end
    bus(1'b1, lic_pkg::IDX_POLARITY, 32'h1);
    for (int v = 0; v < 2; v++) begin
      link <= v[0];
      bus(1'b1, lic_pkg::IDX_CTRL0, 32'h83);
      look({lamp_lit(1, 1'b0, 2'h1), lamp_lit(0, v[0], 2'h1)});
    end
    link <= 1'b0;
    misc <= 5'h1f;
    txa <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, lic_pkg::IDX_CTRL0, 32'h80 | (c == 3 ? 8 : c));
      look({lamp_lit(1, 1'b0, 2'h1), lamp_lit(0, 1'b0, 2'h1)});
    end
    $display("clock and link done");
    misc <= 5'h0;
    txa <= 1'b1;
    bus(1'b1, lic_pkg::IDX_POLARITY, 32'h0);
    bus(1'b1, lic_pkg::IDX_PERIOD, 32'h2);
    bus(1'b1, lic_pkg::IDX_CTRL0, 32'h84);
    repeat (100) @(posedge clk);
    tally(48);
    bus(1'b1, lic_pkg::IDX_CTRL0, 32'h8f);
    tally(48);
    // Full activity must reach the top grade, which needs up to two whole evaluation windows.
    bus(1'b1, lic_pkg::IDX_CTRL0, 32'ha4);
    repeat (10000) @(posedge clk);
    tally(8);
    $display("blink done");
    bus(1'b1, lic_pkg::IDX_POLARITY, 32'ha);
    bus(1'b1, lic_pkg::IDX_CTRL0, 32'h4f);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(lic_pkg::IDX_CTRL0, {16'h0, lic_pkg::CTRL_RESET});
    rd(lic_pkg::IDX_POLARITY, {16'h0, lic_pkg::POL_RESET});
    rd(lic_pkg::IDX_PERIOD, {16'h0, lic_pkg::PERIOD_RESET});
    $display("reset done");
    final_report();
  end
endmodule
